// [logic/mask_rom_io_port.sv]
`timescale 1ns/1ps
`include "rom_io_defs.svh"
// Functional notes
// R1 - Latch address, space, enables on strobe fall
// R2 - Disabled chip ignores access, floats bus, ready
// R3 - Memory read drives ROM byte at address
// R4 - I/O read drives addressed port data
// R5 - Port read strobe acts as I/O read
// R6 - Both read strobes high releases bus
// R7 - Port write strobe loads addressed register
// R8 - Ready low during latch, high next clock
// R9 - I/O decode uses two lowest bits only
// R10 - Host writes first port at bits 00
// R11 - Second port addressed with bits 01
// R12 - Direction bit one output, zero input
// R13 - Direction registers never read back
// R14 - Reset input clears all direction bits
// R15 - Bits 10, 11 select direction registers
// R16 - Port data stored in input mode too
// R17 - Fixed ROM table, memory writes ignored

module mask_rom_io_port
    import rom_io_pkg::*;
#(
    // Fixed ROM image, byte n at index n
    parameter logic [`ROM_DEPTH-1:0][7:0] rom_image = '0
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    input  wire logic                   port_reset,
    input  wire logic                   host_clk,
    input  wire logic                   ale,
    input  wire logic                   io_select,
    input  wire logic                   chip_enable_low,
    input  wire logic                   chip_enable_high,
    input  wire logic [2:0]             upper_rom_lines,
    input  wire logic                   read_strobe_n,
    input  wire logic                   port_read_strobe_n,
    input  wire logic                   port_write_strobe_n,
    input  wire logic [7:0]             shared_bus_in,
    output logic      [7:0]             shared_bus_out,
    output logic                        shared_bus_oe,
    output logic                        ready_out,
    output logic                        ready_oe,
    input  wire logic [`PORT_W-1:0]     first_port_pins_in,
    output logic      [`PORT_W-1:0]     first_port_pins_out,
    output logic      [`PORT_W-1:0]     first_port_pins_oe,
    input  wire logic [`PORT_W-1:0]     second_port_pins_in,
    output logic      [`PORT_W-1:0]     second_port_pins_out,
    output logic      [`PORT_W-1:0]     second_port_pins_oe
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // I/O target from the two lowest latched bits only
    function automatic io_target_t decode_target(input logic [1:0] sel);
        case (sel)
            `SEL_FIRST_PORT:  decode_target = TGT_FIRST_PORT;
            `SEL_SECOND_PORT: decode_target = TGT_SECOND_PORT;
            `SEL_FIRST_DIR:   decode_target = TGT_FIRST_DIR;
            default:          decode_target = TGT_SECOND_DIR;
        endcase
    endfunction : decode_target

    // Enable pair test, used for latched and live enables
    function automatic logic enables_active(input logic ce_low, input logic ce_high);
        enables_active = !ce_low && ce_high;
    endfunction : enables_active

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    addr_latch_t        latch, next_latch;         // Address latch
    logic               ale_q, next_ale_q;         // Strobe history
    logic               host_clk_q, next_host_clk_q;
    logic               write_q, next_write_q;     // Write strobe history
    logic [`PORT_W-1:0] port_data [2];             // Stored port data
    logic [`PORT_W-1:0] next_port_data [2];
    logic [`PORT_W-1:0] port_dir [2];              // Direction registers
    logic [`PORT_W-1:0] next_port_dir [2];
    logic [`PORT_W-1:0] pin_level [2];             // Level shown on pins
    logic [`PORT_W-1:0] next_pin_level [2];
    logic [7:0]         next_bus_out;
    logic               next_bus_oe;
    logic               next_ready;
    logic               next_ready_oe;

    // Combined views
    logic               enabled;                   // Latched chip enable
    logic               write_active;              // Port write in progress
    logic               write_release;             // Write strobe rose
    logic               read_active;               // Any read in progress
    logic               read_io;                   // Read hits port space
    io_target_t         target;                    // Decoded I/O target
    logic [`PORT_W-1:0] pins_in [2];               // Pin inputs by index

    assign pins_in[0] = first_port_pins_in;
    assign pins_in[1] = second_port_pins_in;

    // R2 latched enables gate every access
    assign enabled       = enables_active(latch.chip_enable_low, latch.chip_enable_high);
    // R9 upper lines play no part here
    assign target        = decode_target(latch.addr[1:0]);
    assign write_active  = enabled && !port_write_strobe_n;
    assign write_release = write_q && port_write_strobe_n;
    // R6 both strobes high means no read
    assign read_active   = enabled && (!read_strobe_n || !port_read_strobe_n);
    // R5 port strobe always reads port space
    assign read_io       = !port_read_strobe_n || latch.io_space;

    // ----------------------------------------------------------------
    // Address latch
    // ----------------------------------------------------------------
    // Captures on the cycle the strobe is seen low after high
    always_comb begin
        next_latch = latch;
        next_ale_q = ale;
        // R1 capture on falling latch strobe
        if (ale_q && !ale) begin
            next_latch.addr             = {upper_rom_lines, shared_bus_in};
            next_latch.io_space         = io_select;
            next_latch.chip_enable_low  = chip_enable_low;
            next_latch.chip_enable_high = chip_enable_high;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // Starts deselected so nothing drives until a latch
            latch <= '{addr: '0, io_space: 1'b0, chip_enable_low: 1'b1, chip_enable_high: 1'b0};
            ale_q <= 1'b0;
        end else if (clk_en) begin
            latch <= next_latch;
            ale_q <= next_ale_q;
        end
    end

    // ----------------------------------------------------------------
    // Ports and direction registers
    // ----------------------------------------------------------------
    // Data loads while the strobe is low; the pins follow only when
    // it rises, so output pins hold their level through the write
    always_comb begin
        next_write_q = write_active;
        for (int i = 0; i < 2; i++) begin
            next_port_data[i] = port_data[i];
            next_port_dir[i]  = port_dir[i];
            next_pin_level[i] = pin_level[i];
            // R16 pins update once the write ends
            if (write_release) begin
                next_pin_level[i] = port_data[i];
            end
        end
        // R7 load register picked by latch
        if (write_active) begin
            case (target)
                // R10 first port at bits 00
                TGT_FIRST_PORT:  next_port_data[0] = shared_bus_in;
                // R11 second port at bits 01
                TGT_SECOND_PORT: next_port_data[1] = shared_bus_in;
                // R15 direction registers at 10, 11
                TGT_FIRST_DIR:   next_port_dir[0]  = shared_bus_in;
                TGT_SECOND_DIR:  next_port_dir[1]  = shared_bus_in;
                default:         next_write_q      = write_active;
            endcase
        end
        // R14 reset pin forces input mode
        if (port_reset) begin
            next_port_dir[0] = `DIR_RESET;
            next_port_dir[1] = `DIR_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            write_q <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                port_data[i] <= `DATA_RESET;
                port_dir[i]  <= `DIR_RESET;
                pin_level[i] <= `DATA_RESET;
            end
        end else if (clk_en) begin
            write_q <= next_write_q;
            for (int i = 0; i < 2; i++) begin
                port_data[i] <= next_port_data[i];
                port_dir[i]  <= next_port_dir[i];
                pin_level[i] <= next_pin_level[i];
            end
        end
    end

    // R12 direction bit one drives the pin
    assign first_port_pins_out  = pin_level[0];
    assign first_port_pins_oe   = port_dir[0];
    assign second_port_pins_out = pin_level[1];
    assign second_port_pins_oe  = port_dir[1];

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Output bits return stored data, input bits return the pins
    always_comb begin
        next_bus_out = shared_bus_out;
        next_bus_oe  = read_active;
        if (read_active) begin
            if (read_io) begin
                // R4 port data replaces ROM data
                case (target)
                    TGT_FIRST_PORT:  next_bus_out = (port_dir[0] & port_data[0]) | (~port_dir[0] & pins_in[0]);
                    TGT_SECOND_PORT: next_bus_out = (port_dir[1] & port_data[1]) | (~port_dir[1] & pins_in[1]);
                    // R13 direction contents never returned
                    default:         next_bus_out = `UNREAD_VALUE;
                endcase
            end else begin
                // R3 ROM byte at latched address
                next_bus_out = rom_image[latch.addr];
            end
        end
    end

    // Bus driver lags the strobe by one cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shared_bus_out <= `UNREAD_VALUE;
            shared_bus_oe  <= 1'b0;
        end else if (clk_en) begin
            shared_bus_out <= next_bus_out;
            shared_bus_oe  <= next_bus_oe;
        end
    end

    // ----------------------------------------------------------------
    // Ready generation
    // ----------------------------------------------------------------
    // Host clock is sampled as an ordinary input and edge detected
    always_comb begin
        next_host_clk_q = host_clk;
        next_ready      = ready_out;
        // Enable as it stands after this edge, so the capture edge
        // cannot drop the ready driver for one cycle mid wait
        next_ready_oe   = enables_active(next_latch.chip_enable_low, next_latch.chip_enable_high);
        // R8 low during strobe with enables live
        if (ale && enables_active(chip_enable_low, chip_enable_high)) begin
            next_ready    = 1'b0;
            next_ready_oe = 1'b1;
        // R8 first host clock rise after fall
        end else if (!ale && host_clk && !host_clk_q) begin
            next_ready    = 1'b1;
        end
        // R2 ready floats for a deselected chip
        if (!ale && !enabled && ale_q == 1'b0) begin
            next_ready_oe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            host_clk_q <= 1'b0;
            ready_out  <= `READY_RESET;
            ready_oe   <= 1'b0;
        end else if (clk_en) begin
            host_clk_q <= next_host_clk_q;
            ready_out  <= next_ready;
            ready_oe   <= next_ready_oe;
        end
    end

    // R17 memory space writes have no path
endmodule : mask_rom_io_port

// [logic/rom_io_defs.svh]
`ifndef ROM_IO_DEFS_SVH
`define ROM_IO_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define ROM_DEPTH        2048
`define ROM_ADDR_W       11
`define PORT_W           8

// ----------------------------------------------------------------
// I/O select codes on the two lowest latched address bits
// ----------------------------------------------------------------
`define SEL_FIRST_PORT   2'h0
`define SEL_SECOND_PORT  2'h1
`define SEL_FIRST_DIR    2'h2
`define SEL_SECOND_DIR   2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DIR_RESET        8'h00
`define DATA_RESET       8'h00
`define UNREAD_VALUE     8'h00
`define READY_RESET      1'b1

`endif

// [logic/rom_io_pkg.sv]
`include "rom_io_defs.svh"

package rom_io_pkg;

    // ----------------------------------------------------------------
    // Values caught on the falling edge of the latch strobe
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`ROM_ADDR_W-1:0] addr;             // Low byte plus upper lines
        logic                   io_space;         // High selects ports
        logic                   chip_enable_low;  // Active-low enable
        logic                   chip_enable_high; // Active-high enable
    } addr_latch_t;

    // ----------------------------------------------------------------
    // One eight-bit two-way port at the pins
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`PORT_W-1:0] data_out;  // Level driven on output pins
        logic [`PORT_W-1:0] oe;        // High where the pin is driven
    } port_drive_t;

    // Target selected by an I/O access
    typedef enum logic [1:0] {
        TGT_FIRST_PORT,
        TGT_SECOND_PORT,
        TGT_FIRST_DIR,
        TGT_SECOND_DIR
    } io_target_t;

endpackage : rom_io_pkg

// [test/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       clk,
    input  wire logic [7:0] shared_bus_out,
    input  wire logic       shared_bus_oe,
    input  wire logic       ready_out,
    input  wire logic       ready_oe,
    output logic            host_clk,
    output logic            ale,
    output logic            io_select,
    output logic            chip_enable_low,
    output logic            chip_enable_high,
    output logic [2:0]      upper_rom_lines,
    output logic            read_strobe_n,
    output logic            port_read_strobe_n,
    output logic            port_write_strobe_n,
    output logic [7:0]      shared_bus_in
);
    // ----------------------------------------------------------------
    // Host processor: free-running clock and bus cycles
    // ----------------------------------------------------------------
    logic [1:0] hcnt  = 2'h0;  // Host clock divider
    logic       drive = 1'b0;  // Host owns the bus
    logic [7:0] dval  = 8'h00; // Host bus value
    logic [7:0] last  = 8'h00; // Previous bus level
    int         timeouts = 0;  // Waits that ran out
    logic       wait_seen = 1'b0; // Wait state seen in address phase
    // Released bus flips each cycle so a stale value never matches
    assign shared_bus_in = shared_bus_oe ? shared_bus_out : drive ? dval : ~last;
    assign host_clk = hcnt[1];
    always @(posedge clk) last <= shared_bus_in;
    always @(negedge clk) hcnt <= hcnt + 2'h1;
    initial begin
        {ale, io_select, upper_rom_lines} = 5'h00;
        {chip_enable_low, chip_enable_high} = 2'h2;
        {read_strobe_n, port_read_strobe_n, port_write_strobe_n} = 3'h7;
    end
    task automatic start(input logic io, input logic [1:0] ce, input logic [10:0] addr);
        int n;
        @(negedge clk);
        {ale, io_select, upper_rom_lines} = {1'b1, io, addr[10:8]};
        {chip_enable_low, chip_enable_high} = ce;
        {drive, dval} = {1'b1, addr[7:0]};
        @(negedge clk);
        wait_seen = ready_oe && !ready_out;
        ale = 1'b0;
        @(negedge clk);
        drive = 1'b0;
        // Strobes wait out the wait state
        for (n = 0; n < 16 && ready_oe && !ready_out; n++) @(negedge clk);
        if (n == 16) timeouts++;
    endtask : start
    // Answer lands one edge after the strobe
    task automatic read(input logic port_strobe, output logic [7:0] data, output logic oe);
        @(negedge clk);
        {read_strobe_n, port_read_strobe_n} = port_strobe ? 2'h2 : 2'h1;
        @(negedge clk);
        @(negedge clk);
        {data, oe} = {shared_bus_in, shared_bus_oe};
        {read_strobe_n, port_read_strobe_n} = 2'h3;
        @(negedge clk);
    endtask : read
    // Data held one cycle past the strobe rise
    task automatic write(input logic [7:0] data);
        @(negedge clk);
        {drive, dval, port_write_strobe_n} = {1'b1, data, 1'b0};
        @(negedge clk);
        @(negedge clk);
        port_write_strobe_n = 1'b1;
        @(negedge clk);
        drive = 1'b0;
        @(negedge clk);
    endtask : write
endmodule : host_bus_model

// [test/mask_rom_io_port_asserts.sv]
`timescale 1ns/1ps
module mask_rom_io_port_asserts (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       port_reset,
    input wire logic       host_clk,
    input wire logic       ale,
    input wire logic       chip_enable_low,
    input wire logic       chip_enable_high,
    input wire logic       read_strobe_n,
    input wire logic       port_read_strobe_n,
    input wire logic       port_write_strobe_n,
    input wire logic [7:0] shared_bus_in,
    input wire logic       shared_bus_oe,
    input wire logic       ready_out,
    input wire logic       ready_oe,
    input wire logic [7:0] first_port_pins_oe,
    input wire logic [7:0] second_port_pins_oe
);
    // ----------------------------------------------------------------
    // Shadow of the address latch
    // ----------------------------------------------------------------
    logic       ale_q, hclk_q, en_q;           // Delayed strobe, host clock, latched enable
    logic [1:0] sel_q;                         // Latched target bits
    logic       next_en;
    logic [1:0] next_sel;
    wire        take = ale_q && !ale;          // Strobe fall, same edge as the device
    wire        wr   = en_q && !port_reset && !port_write_strobe_n;
    // Capture on the fall only; holds otherwise
    always_comb begin
        next_en  = take ? (!chip_enable_low && chip_enable_high) : en_q;
        next_sel = take ? shared_bus_in[1:0] : sel_q;
    end
    // Reset to deselected, as the device does
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {ale_q, hclk_q, en_q, sel_q} <= '0;
        end else begin
            {ale_q, hclk_q, en_q, sel_q} <= {ale, host_clk, next_en, next_sel};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_QUIET_OFF: assert property (!en_q && $past(!en_q) |-> !shared_bus_oe)
        else $error("bus driven while deselected");
    AST_READ_ON: assert property (en_q && !(read_strobe_n && port_read_strobe_n) |=> shared_bus_oe)
        else $error("read not answered");
    AST_READ_OFF: assert property (read_strobe_n && port_read_strobe_n |=> !shared_bus_oe)
        else $error("bus held after read");
    AST_DIR_FIRST: assert property (wr && sel_q == 2'h2 |=> first_port_pins_oe == $past(shared_bus_in))
        else $error("first direction not loaded");
    AST_DIR_SECOND: assert property (wr && sel_q == 2'h3 |=> second_port_pins_oe == $past(shared_bus_in))
        else $error("second direction not loaded");
    AST_PORT_RESET: assert property (port_reset |=> (first_port_pins_oe | second_port_pins_oe) == 8'h00)
        else $error("directions not cleared");
    AST_READY_WAIT: assert property (ale && !chip_enable_low && chip_enable_high |=> !ready_out && ready_oe)
        else $error("no wait state");
    AST_READY_BACK: assert property (!ready_out && !ale && !hclk_q && host_clk |-> ##[1:2] ready_out)
        else $error("wait state too long");
    COV_ROM_READ: cover property (en_q && !read_strobe_n);
    COV_PORT_WRITE: cover property (wr);
    COV_WAIT: cover property ($fell(ready_out));
endmodule : mask_rom_io_port_asserts

bind mask_rom_io_port mask_rom_io_port_asserts i_mask_rom_io_port_asserts (
    .clk, .reset_n, .port_reset, .host_clk, .ale, .chip_enable_low, .chip_enable_high, .read_strobe_n,
    .port_read_strobe_n, .port_write_strobe_n, .shared_bus_in, .shared_bus_oe, .ready_out, .ready_oe,
    .first_port_pins_oe, .second_port_pins_oe);

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       port_reset = 1'b0;
    logic [7:0] first_port_pins_in = 8'h00;
    logic [7:0] second_port_pins_in = 8'h00;
    logic [7:0] shared_bus_in, shared_bus_out, first_port_pins_out, first_port_pins_oe;
    logic [7:0] second_port_pins_out, second_port_pins_oe, rd;
    logic [2:0] upper_rom_lines;
    logic       shared_bus_oe, ready_out, ready_oe, host_clk, ale, io_select, rd_oe;
    logic       chip_enable_low, chip_enable_high, read_strobe_n, port_read_strobe_n, port_write_strobe_n;
    int         err_total = 0;
    int         cmp_count = 0;
    // Known ROM pattern, distinct across pages
    function automatic logic [7:0] rom_byte(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h00};
    endfunction : rom_byte
    function automatic logic [2047:0][7:0] rom_fill();
        for (int a = 0; a < 2048; a++) rom_fill[a] = rom_byte(11'(a));
    endfunction : rom_fill
    always #50 clk = ~clk;
    mask_rom_io_port #(.rom_image(rom_fill())) i_mask_rom_io_port (
        .clk, .reset_n, .clk_en(1'b1), .port_reset, .host_clk, .ale, .io_select, .chip_enable_low,
        .chip_enable_high, .upper_rom_lines, .read_strobe_n, .port_read_strobe_n, .port_write_strobe_n,
        .shared_bus_in, .shared_bus_out, .shared_bus_oe, .ready_out, .ready_oe, .first_port_pins_in,
        .first_port_pins_out, .first_port_pins_oe, .second_port_pins_in, .second_port_pins_out,
        .second_port_pins_oe);
    host_bus_model i_host_bus_model (
        .clk, .shared_bus_out, .shared_bus_oe, .ready_out, .ready_oe, .host_clk, .ale, .io_select,
        .chip_enable_low, .chip_enable_high, .upper_rom_lines, .read_strobe_n, .port_read_strobe_n,
        .port_write_strobe_n, .shared_bus_in);
    // Enables are {active-low, active-high}
    task automatic acc_rd(input logic io, input logic [1:0] ce, input logic [10:0] a, input logic ps);
        i_host_bus_model.start(io, ce, a);
        check("ready", 8'h01, {7'h00, ready_out});
        i_host_bus_model.read(ps, rd, rd_oe);
    endtask : acc_rd
    task automatic acc_wr(input logic [1:0] ce, input logic [10:0] a, input logic [7:0] d);
        i_host_bus_model.start(1'b1, ce, a);
        i_host_bus_model.write(d);
    endtask : acc_wr
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        err_total += i_host_bus_model.timeouts;
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // ROM at both ends and mid array
    task automatic t_rom();
        logic [10:0] a [3] = '{11'h000, 11'h7ff, 11'h2a5};
        foreach (a[i]) begin
            acc_rd(1'b0, 2'h1, a[i], 1'b0);
            check("rom", rom_byte(a[i]), rd);
            check("wait", 8'h01, {7'h00, i_host_bus_model.wait_seen});
        end
    endtask : t_rom
    // Data stored while input, then pins turned to output
    task automatic t_first();
        acc_wr(2'h1, 11'h000, 8'ha5);
        acc_wr(2'h1, 11'h002, 8'hff);
        check("dir_a", 8'hff, first_port_pins_oe);
        check("out_a", 8'ha5, first_port_pins_out);
        acc_rd(1'b1, 2'h1, 11'h000, 1'b1);
        check("ior_a", 8'ha5, rd);
        acc_rd(1'b1, 2'h1, 11'h000, 1'b0);
        check("rd_a", 8'ha5, rd);
    endtask : t_first
    // Upper lines set; low nibble output, high nibble input
    task automatic t_second();
        second_port_pins_in = 8'ha0;
        acc_wr(2'h1, 11'h703, 8'h0f);
        acc_wr(2'h1, 11'h501, 8'h3c);
        check("dir_b", 8'h0f, second_port_pins_oe);
        acc_rd(1'b1, 2'h1, 11'h601, 1'b1);
        check("ior_b", 8'hac, rd);
        check("out_b", 8'h3c, second_port_pins_out);
        acc_rd(1'b1, 2'h1, 11'h403, 1'b0);
        check("dir_rd", 8'h00, rd);
    endtask : t_second
    // Both ways of deselecting block port writes and port reads
    task automatic t_off();
        logic [1:0] ce [2] = '{2'h3, 2'h0};
        foreach (ce[i]) begin
            acc_wr(ce[i], 11'h000, 8'h5a);
            check("off_wait", 8'h00, {7'h00, i_host_bus_model.wait_seen});
            check("ready_oe", 8'h00, {7'h00, ready_oe});
            acc_rd(1'b1, ce[i], 11'h000, 1'b1);
            check("off_oe", 8'h00, {7'h00, rd_oe});
        end
        check("out_a", 8'ha5, first_port_pins_out);
    endtask : t_off
    // Reset pin clears directions, keeps data
    task automatic t_port_reset();
        port_reset = 1'b1;
        @(negedge clk);
        port_reset = 1'b0;
        check("dir_a", 8'h00, first_port_pins_oe);
        check("dir_b", 8'h00, second_port_pins_oe);
        acc_wr(2'h1, 11'h002, 8'hff);
        check("out_a", 8'ha5, first_port_pins_out);
    endtask : t_port_reset
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        check("bus_oe", 8'h00, {7'h00, shared_bus_oe});
        check("dir_a", 8'h00, first_port_pins_oe);
        t_rom();
        t_first();
        t_second();
        t_off();
        t_port_reset();
        conclude();
    end
endmodule : testbench
